// ---- picfg_consts.svh ----
// Register offsets, field positions, reset values and timing of the config block
`ifndef PICFG_CONSTS_SVH
`define PICFG_CONSTS_SVH
`define PICFG_CFG_OFFSET 16'hd060
`define PICFG_ADDR_W 16
`define PICFG_BIT_SWAP_A 11
`define PICFG_BIT_SWAP_B 10
`define PICFG_BIT_SWAP_C 9
`define PICFG_BIT_SWAP_IO 8
`define PICFG_BIT_EN_A 7
`define PICFG_BIT_EN_B 6
`define PICFG_BIT_EN_C 5
`define PICFG_BIT_EN_IO 4
`define PICFG_BIT_RDERR 3
`define PICFG_CFG_MASK 32'h0000_0ff8
`define PICFG_RDERR_RESET 1'h1
`define PICFG_STRAP_LOAD 2'h2
`define PICFG_STRAP_DONE 2'h3
`define PICFG_SPACES 4
`define PICFG_SP_A 2'h0
`define PICFG_SP_B 2'h1
`define PICFG_SP_C 2'h2
`define PICFG_SP_IO 2'h3
`endif

// ---- picfg_pkg.sv ----
// Types shared by the initiator space configuration block
package picfg_pkg;
  // Decoded space of an internal bus request
  typedef enum logic [1:0] {
    PICFG_SPACE_A = 2'b00,
    PICFG_SPACE_B = 2'b01,
    PICFG_SPACE_C = 2'b10,
    PICFG_SPACE_IO = 2'b11
  } picfg_space_t;

  // Internal bus request towards the PCI initiator
  typedef struct packed {
    logic valid;
    logic write;
    picfg_space_t space;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } picfg_req_t;

  // Outcome of one initiator cycle as seen by the internal bus
  typedef struct packed {
    logic done;
    logic bus_error;
    logic [31:0] rdata;
  } picfg_rsp_t;

  // PCI side status flags reported at the end of an initiator cycle
  typedef struct packed {
    logic direct_fatal_error_flag;
    logic direct_parity_error_flag;
    logic master_abort_received_flag;
    logic target_abort_received_flag;
    logic ready_wait_timeout_flag;
    logic retry_count_timeout_flag;
  } picfg_err_t;

  // Configuration fields held by the register
  typedef struct packed {
    logic [3:0] swap;
    logic [3:0] enable;
    logic read_error_bus_fault_select;
  } picfg_cfg_t;
endpackage

// ---- picfg_swap.sv ----
// Byte lane reversal of one 32-bit word and its byte enables
`timescale 1ns/1ps
module picfg_swap (
  input wire logic swap,
  input wire logic [31:0] din,
  input wire logic [3:0] be_in,
  output logic [31:0] dout,
  output logic [3:0] be_out
);
  import picfg_pkg::*;

  // Lane i maps to lane 3-i when swapping
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_lane
      assign dout[8*i +: 8] = swap ? din[8*(3-i) +: 8] : din[8*i +: 8];
      assign be_out[i] = swap ? be_in[3-i] : be_in[i];
    end
  endgenerate
endmodule

// ---- picfg_apb.sv ----
// APB slave front end holding the configuration register
`timescale 1ns/1ps
`include "picfg_consts.svh"
module picfg_apb (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic big_endian,
  input wire logic pci_boot,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output picfg_pkg::picfg_cfg_t cfg
);
  import picfg_pkg::*;

  typedef struct packed {
    logic [1:0] settle;
    picfg_cfg_t cfg;
    logic [31:0] rdata;
  } picfg_apb_st_t;

  picfg_apb_st_t st_reg;
  picfg_apb_st_t st_next;
  logic hit;
  logic [31:0] cur;

  assign hit = (paddr == `PICFG_CFG_OFFSET);
  assign cfg = st_reg.cfg;
  assign prdata = st_reg.rdata;
  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Register image, reserved bits read zero
  always_comb begin
    cur = 32'h0000_0000;
    cur[`PICFG_BIT_SWAP_A] = st_reg.cfg.swap[`PICFG_SP_A];
    cur[`PICFG_BIT_SWAP_B] = st_reg.cfg.swap[`PICFG_SP_B];
    cur[`PICFG_BIT_SWAP_C] = st_reg.cfg.swap[`PICFG_SP_C];
    cur[`PICFG_BIT_SWAP_IO] = st_reg.cfg.swap[`PICFG_SP_IO];
    cur[`PICFG_BIT_EN_A] = st_reg.cfg.enable[`PICFG_SP_A];
    cur[`PICFG_BIT_EN_B] = st_reg.cfg.enable[`PICFG_SP_B];
    cur[`PICFG_BIT_EN_C] = st_reg.cfg.enable[`PICFG_SP_C];
    cur[`PICFG_BIT_EN_IO] = st_reg.cfg.enable[`PICFG_SP_IO];
    cur[`PICFG_BIT_RDERR] = st_reg.cfg.read_error_bus_fault_select;
  end

  // Next state: strap load once synchronisers settle, then bus writes
  always_comb begin
    st_next = st_reg;
    // Reset clears the strap synchronisers, so their output is only
    // trustworthy two cycles after release; writes up to the strap load in the third cycle are lost
    if (st_reg.settle != `PICFG_STRAP_DONE) begin
      st_next.settle = st_reg.settle + 2'h1;
    end
    if (st_reg.settle == `PICFG_STRAP_LOAD) begin
      // R5: strap defaults
      st_next.cfg.swap = {4{big_endian}};
      // R9: boot default
      st_next.cfg.enable[`PICFG_SP_C] = pci_boot;
    end else if (st_reg.settle == `PICFG_STRAP_DONE && psel && penable &&
        hit && pwrite) begin
      // R1: swap A written
      st_next.cfg.swap[`PICFG_SP_A] = pwdata[`PICFG_BIT_SWAP_A];
      // R2: swap B written
      st_next.cfg.swap[`PICFG_SP_B] = pwdata[`PICFG_BIT_SWAP_B];
      // R3: swap C written
      st_next.cfg.swap[`PICFG_SP_C] = pwdata[`PICFG_BIT_SWAP_C];
      // R4: swap IO written
      st_next.cfg.swap[`PICFG_SP_IO] = pwdata[`PICFG_BIT_SWAP_IO];
      // R7: enable A written
      st_next.cfg.enable[`PICFG_SP_A] = pwdata[`PICFG_BIT_EN_A];
      // R8: enable B written
      st_next.cfg.enable[`PICFG_SP_B] = pwdata[`PICFG_BIT_EN_B];
      // R9: enable C written
      st_next.cfg.enable[`PICFG_SP_C] = pwdata[`PICFG_BIT_EN_C];
      // R10: enable IO written
      st_next.cfg.enable[`PICFG_SP_IO] = pwdata[`PICFG_BIT_EN_IO];
      // R11: error response select
      st_next.cfg.read_error_bus_fault_select = pwdata[`PICFG_BIT_RDERR];
    end
    // Read data latched in setup so it is stable in the access phase
    if (psel && !penable) begin
      st_next.rdata = (hit && !pwrite) ? cur : 32'h0000_0000;
    end
  end

  // Constants only under reset; straps are caught three cycles after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.cfg.read_error_bus_fault_select <= `PICFG_RDERR_RESET;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end
endmodule

// ---- picfg_top.sv ----
// Initiator space configuration: register, space gating, swap, error answer
//
// Behaviour
// R1: Bit 11 set reverses bytes of transfers to memory space A.
// R2: Bit 10 set reverses bytes of transfers to memory space B.
// R3: Bit 9 set reverses bytes of transfers to memory space C.
// R4: Bit 8 set reverses bytes of transfers to I/O space.
// R5: Swap bits reset to the endian strap and are read/write.
// R6: Clearing swap in big endian keeps 32-bit word order unchanged.
// R7: Bit 7 enables memory space A; resets to 0.
// R8: Bit 6 enables memory space B; resets to 0.
// R9: Bit 5 enables memory space C; resets to 0, or 1 on PCI boot.
// R10: Bit 4 enables I/O space; resets to 0.
// R11: Bit 3 resets to 1 and selects the read error answer.
// R12: At 1 a failing read ends in bus error, else invalid data.
// R13: Covered errors: fatal, parity, master/target abort, two timeouts.
// R14: Disabled spaces start no PCI initiator cycle.
`timescale 1ns/1ps
`include "picfg_consts.svh"
module picfg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic big_endian,
  input wire logic pci_boot,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire picfg_pkg::picfg_req_t ib_req,
  output logic ib_ready,
  output picfg_pkg::picfg_rsp_t ib_rsp,
  output picfg_pkg::picfg_req_t pci_req,
  input wire logic pci_ready,
  input wire logic pci_done,
  input wire logic [31:0] pci_rdata,
  input wire picfg_pkg::picfg_err_t pci_err
);
  import picfg_pkg::*;

  typedef enum logic [1:0] {
    PICFG_IDLE = 2'b00,
    PICFG_ISSUE = 2'b01,
    PICFG_WAIT = 2'b10,
    PICFG_ANSWER = 2'b11
  } picfg_state_t;

  typedef struct packed {
    logic [1:0] big_sync;
    logic [1:0] boot_sync;
    picfg_state_t state;
    picfg_req_t req;
    picfg_rsp_t rsp;
  } picfg_st_t;

  picfg_st_t st_reg;
  picfg_st_t st_next;
  picfg_cfg_t cfg;
  logic space_swap;
  logic space_en;
  logic [31:0] wdata_sw;
  logic [3:0] be_sw;
  logic [31:0] rdata_sw;
  logic any_err;

  // Straps come from pins, so they pass two flops first
  picfg_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .big_endian(st_reg.big_sync[1]),
    .pci_boot(st_reg.boot_sync[1]),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg)
  );

  // Per-space selection of swap and enable
  // R1: swap per space
  assign space_swap = cfg.swap[ib_req.space];
  // R14: gate by enable
  assign space_en = cfg.enable[ib_req.space];

  // R6: one reversal per word keeps a cleared space word-ordered
  picfg_swap u_wswap (
    .swap(space_swap),
    .din(ib_req.wdata),
    .be_in(ib_req.be),
    .dout(wdata_sw),
    .be_out(be_sw)
  );

  // R4: returning data uses the swap of the captured space
  picfg_swap u_rswap (
    .swap(cfg.swap[st_reg.req.space]),
    .din(pci_rdata),
    .be_in(4'h0),
    .dout(rdata_sw),
    .be_out()
  );

  // R13: any listed PCI or bridge error fails a read cycle; writes end without error
  assign any_err = |pci_err;

  assign ib_ready = (st_reg.state == PICFG_IDLE);
  assign pci_req = st_reg.req;
  assign ib_rsp = st_reg.rsp;

  // Request sequencer between internal bus and PCI initiator
  always_comb begin
    st_next = st_reg;
    st_next.big_sync = {st_reg.big_sync[0], big_endian};
    st_next.boot_sync = {st_reg.boot_sync[0], pci_boot};
    st_next.rsp.done = 1'b0;
    st_next.rsp.bus_error = 1'b0;
    case (st_reg.state)
      PICFG_IDLE: begin
        if (ib_req.valid) begin
          if (space_en) begin
            // R14: only enabled spaces reach PCI
            st_next.req = ib_req;
            st_next.req.wdata = wdata_sw;
            st_next.req.be = be_sw;
            st_next.state = PICFG_ISSUE;
          end else begin
            // Disabled space: answer locally with a bus error
            st_next.rsp.done = 1'b1;
            st_next.rsp.bus_error = 1'b1;
            st_next.rsp.rdata = 32'h0000_0000;
            st_next.state = PICFG_ANSWER;
          end
        end
      end
      PICFG_ISSUE: begin
        if (pci_ready) begin
          st_next.req.valid = 1'b0;
          st_next.state = PICFG_WAIT;
        end
      end
      PICFG_WAIT: begin
        if (pci_done) begin
          st_next.rsp.done = 1'b1;
          st_next.rsp.rdata = rdata_sw;
          // R12: error answer on reads per select bit
          if (any_err && !st_reg.req.write) begin
            st_next.rsp.bus_error = cfg.read_error_bus_fault_select;
          end
          st_next.state = PICFG_ANSWER;
        end
      end
      PICFG_ANSWER: begin
        // One-cycle gap keeps the done pulse single
        st_next.state = PICFG_IDLE;
      end
      default: begin
        st_next.state = PICFG_IDLE;
      end
    endcase
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end
endmodule

// ---- picfg_assertions.sv ----
// Checker of the config block port timing
`timescale 1ns/1ps
module picfg_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [15:0] paddr,
  input wire logic pslverr,
  input wire picfg_pkg::picfg_req_t ib_req,
  input wire logic ib_ready,
  input wire picfg_pkg::picfg_rsp_t ib_rsp,
  input wire picfg_pkg::picfg_req_t pci_req,
  input wire logic pci_done,
  input wire picfg_pkg::picfg_err_t pci_err
);
  import picfg_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_take;
    ib_req.valid && ib_ready;
  endsequence
  AST_UNMAPPED: assert property (
    s_acc ##0 paddr != 16'hd060 |-> pslverr)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (
    s_acc ##0 paddr == 16'hd060 |-> !pslverr)
    else $error("mapped access refused");
  AST_ANSWER: assert property (
    s_take |-> ##[1:60] ib_rsp.done)
    else $error("request not answered");
  AST_BUSY: assert property (
    s_take |=> !ib_ready until ib_rsp.done)
    else $error("ready before answer");
  AST_PULSE: assert property (
    ib_rsp.done |=> !ib_rsp.done && ib_ready)
    else $error("done not a pulse");
  AST_PCI_END: assert property (
    pci_done |=> ib_rsp.done)
    else $error("no answer after pci end");
  AST_CLEAN: assert property (
    pci_done && pci_err == '0 |=> !ib_rsp.bus_error)
    else $error("bus error without pci error");
  AST_START: assert property (
    $rose(pci_req.valid) |-> $past(ib_req.valid && ib_ready))
    else $error("pci cycle without request");
endmodule
bind picfg_top picfg_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .ib_req(ib_req), .ib_ready(ib_ready), .ib_rsp(ib_rsp),
  .pci_req(pci_req), .pci_done(pci_done), .pci_err(pci_err));

// ---- picfg_pci_target.sv ----
// Behavioural PCI target behind the initiator request port
`timescale 1ns/1ps
module picfg_pci_target (
  input wire logic pclk,
  input wire logic presetn,
  input wire picfg_pkg::picfg_req_t req,
  input wire logic [3:0] lat,
  input wire logic [31:0] rd_word,
  input wire picfg_pkg::picfg_err_t err_in,
  output logic pci_ready,
  output logic pci_done,
  output logic [31:0] pci_rdata,
  output picfg_pkg::picfg_err_t pci_err
);
  import picfg_pkg::*;
  logic busy;
  logic [3:0] cnt;
  // Accept one request, end it lat+1 cycles after acceptance; lines carry junk
  // outside the end cycle so a stale word is never mistaken for data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      pci_ready <= 1'b0;
      pci_done <= 1'b0;
      pci_rdata <= 32'h0;
      pci_err <= '0;
    end else begin
      pci_ready <= 1'b0;
      pci_done <= 1'b0;
      pci_rdata <= ~pci_rdata;
      pci_err <= ~pci_err;
      if (!busy && req.valid && !pci_ready) begin
        pci_ready <= 1'b1;
        busy <= 1'b1;
        cnt <= lat;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        pci_done <= 1'b1;
        pci_rdata <= rd_word;
        pci_err <= err_in;
      end
    end
  end
endmodule

// ---- pci_initiator_space_config_bench.sv ----
// Self-checking bench of the initiator space config block
`timescale 1ns/1ps
module pci_initiator_space_config_bench;
  import picfg_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, sbe = 1'b0, sboot = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slv;
  logic pready, pslverr, ib_ready, pci_ready, pci_done;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, rword = 32'ha1b2_c3d4, prdata, pci_rdata, rd;
  logic [3:0] lat = 4'h0;
  picfg_req_t ireq = '0, pci_req, seen;
  picfg_rsp_t ib_rsp;
  picfg_err_t perr = '0, pci_err;
  int n_fail = 0, check_count = 0;
  always #10 pclk = ~pclk;
  picfg_top dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .big_endian(sbe), .pci_boot(sboot), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ib_req(ireq), .ib_ready(ib_ready),
    .ib_rsp(ib_rsp), .pci_req(pci_req), .pci_ready(pci_ready),
    .pci_done(pci_done), .pci_rdata(pci_rdata), .pci_err(pci_err));
  picfg_pci_target tgt (.pclk(pclk), .presetn(presetn), .req(pci_req),
    .lat(lat), .rd_word(rword), .err_in(perr), .pci_ready(pci_ready),
    .pci_done(pci_done), .pci_rdata(pci_rdata), .pci_err(pci_err));
  task automatic results();
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_w(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_b(input string n, input logic e, g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask
  function automatic logic [31:0] cw(input logic [3:0] s, e, input logic r);
    return {20'h0, s, e, r, 3'h0};
  endfunction
  function automatic logic [31:0] bsw(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  // Straps are set while reset is held and settle through their synchronisers after release
  task automatic rst(input logic b, t);
    presetn <= 1'b0;
    sbe <= b;
    sboot <= t;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Internal bus word to space s; en, sw and eb are the expectations
  task automatic xfer(input logic w, input picfg_space_t s, logic en, sw, eb);
    int n;
    logic [31:0] wd;
    wd = {8'h11, 8'h22, 8'h33, 6'h0, s};
    ireq <= '{1'b1, w, s, 32'h0000_0100, wd, 4'h3};
    do @(posedge pclk); while (ib_ready !== 1'b1);
    ireq.valid <= 1'b0;
    seen = '0;
    n = 0;
    while (ib_rsp.done !== 1'b1 && n < 80) begin
      @(posedge pclk);
      if (pci_req.valid === 1'b1) seen = pci_req;
      n++;
    end
    chk_b("done", 1'b1, ib_rsp.done);
    chk_b("pci_start", en, seen.valid);
    chk_b("bus_error", eb, ib_rsp.bus_error);
    if (en) chk_w("pci_be", sw ? 32'hc : 32'h3, {28'h0, seen.be});
    if (en) chk_w("pci_addr", 32'h0000_0100, seen.addr);
    if (en) chk_w("pci_cmd", {29'h0, w, s}, {29'h0, seen.write, seen.space});
    if (en && w) chk_w("pci_wdata", sw ? bsw(wd) : wd, seen.wdata);
    if (en && !w && perr == '0)
      chk_w("rdata", sw ? bsw(rword) : rword, ib_rsp.rdata);
  endtask
  task automatic t_reset(input logic b, t);
    rst(b, t);
    apb(1'b0, 16'hd060, 32'h0);
    chk_w("cfg_reset", cw({4{b}}, {2'h0, t, 1'h0}, 1'b1), rd);
    apb(1'b1, 16'hd064, 32'hffff_ffff);
    chk_b("slverr", 1'b1, slv);
    apb(1'b1, 16'hd060, 32'hffff_ffff);
    apb(1'b0, 16'hd060, 32'h0);
    chk_w("cfg_ones", 32'h0000_0ff8, rd);
  endtask
  // Swap one space while all others hold the opposite setting
  task automatic t_swap();
    logic [3:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 4'h8 >> i[2:1];
      apb(1'b1, 16'hd060, cw(i[0] ? m : ~m, 4'hf, 1'b1));
      xfer(1'b1, picfg_space_t'(i[2:1]), 1'b1, i[0], 1'b0);
      xfer(1'b0, picfg_space_t'(i[2:1]), 1'b1, i[0], 1'b0);
    end
  endtask
  // Disabled space refused locally while the others stay enabled
  task automatic t_off();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 16'hd060, cw(4'h0, ~(4'h8 >> i), 1'b0));
      xfer(1'b0, picfg_space_t'(i), 1'b0, 1'b0, 1'b1);
    end
  endtask
  // Each fault flag, both answer settings, slow target too
  task automatic t_err();
    for (int i = 0; i < 6; i++) begin
      perr <= picfg_err_t'(6'h20 >> i);
      lat <= 4'(i * 3);
      for (int r = 0; r < 2; r++) begin
        apb(1'b1, 16'hd060, cw(4'h0, 4'hf, r[0]));
        xfer(1'b0, PICFG_SPACE_A, 1'b1, 1'b0, r[0]);
      end
      xfer(1'b1, PICFG_SPACE_B, 1'b1, 1'b0, 1'b0);
    end
    perr <= '0;
    lat <= 4'h0;
  endtask
  initial begin
    t_reset(1'b0, 1'b0);
    t_swap();
    t_off();
    t_err();
    t_reset(1'b1, 1'b1);
    t_swap();
    results();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    results();
  end
endmodule
